// [rtl/fbs_status_flags.sv]
// Purpose: fieldbus master status flag bank with bus-state gating
// Assumes: net fault sense is an async pin; other inputs share clk_in
// Notes:   all outputs registered; flags aligned to the state register
//
// Functional notes
// [R01] Address conflict sets the conflict flag and starts back-off.
// [R02] Back-off silences the bus about five seconds, restarting on each conflict.
// [R03] Network fault flag follows the physical fault sense.
// [R04] Slave fault flag is one while any slave reports a fault.
// [R05] Off flag while bus state is off; no transmission then.
// [R06] Halted flag while halted; talks but exchanges no process data.
// [R07] Held flag while held; exchanges data but sends no outputs.
// [R08] Running flag while running; full process data exchange.
// [R09] Slave emulation flag reflects slave-mode configuration.
// [R10] Host running flag is one while host is in run mode.
// [R11] Host running flag is zero in program or fault mode.
// [R12] Exactly one of the four bus-state flags is set.
`timescale 1ns/1ps
`default_nettype none
module fbs_status_flags #(
    parameter int unsigned BACKOFF_CYC = fbs_pkg::BACKOFF_CYCLES,
    parameter int unsigned SLV_N       = fbs_pkg::SLAVE_COUNT
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             clk_en_in,
    input  wire logic             addr_conflict_in,
    input  wire logic             net_fault_pin_in,
    input  wire logic [SLV_N-1:0] slave_err_in,
    input  wire logic [1:0]       bus_state_req_in,
    input  wire logic             slave_mode_cfg_in,
    input  wire logic             host_run_in,
    input  wire logic             host_fault_in,
    output logic                  station_address_conflict_out,
    output logic                  network_fault_flag_out,
    output logic                  slave_fault_flag_out,
    output logic                  bus_state_off_out,
    output logic                  bus_state_halted_out,
    output logic                  bus_state_outputs_held_out,
    output logic                  bus_state_running_out,
    output logic                  slave_emulation_active_out,
    output logic                  host_cpu_running_out,
    output logic                  tx_enable_out,
    output logic                  xchg_enable_out,
    output logic                  out_data_enable_out
);
    generate
        if (SLV_N < 1)
        begin : g_chk
            $error("at least one slave status line is needed");
        end
    endgenerate

    fbs_backoff_if bo ();

    fbs_pkg::fbs_bus_state_t      state_r;
    fbs_pkg::fbs_bus_state_t      state_nxt;
    logic [fbs_pkg::FLAG_W-1:0]   flags_r;
    logic [fbs_pkg::FLAG_W-1:0]   flags_nxt;
    logic                         net_s1_r;
    logic                         net_s2_r;
    logic                         net_fault_r;
    logic                         slave_fault_r;
    logic                         slave_emu_r;
    logic                         host_run_r;
    logic                         tx_en_r;
    logic                         tx_en_nxt;
    logic                         xchg_en_r;
    logic                         out_en_r;

    assign bo.en       = clk_en_in;
    assign bo.conflict = addr_conflict_in;

    fbs_backoff #(
        .BACKOFF_CYC (BACKOFF_CYC)
    ) u_backoff (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .bo       (bo)
    );

    assign state_nxt = clk_en_in ? fbs_pkg::fbs_bus_state_t'(bus_state_req_in) : state_r;
    assign flags_nxt = fbs_pkg::fbs_state_flags(state_nxt);

    // bus state register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state_r <= fbs_pkg::BUS_STATE_RST;
        else
            state_r <= state_nxt;
    end

    // [R12] one-hot state flags
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            flags_r <= fbs_pkg::FLAGS_RST;
        else
            flags_r <= flags_nxt;
    end

    // fault sense synchroniser
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            net_s1_r <= fbs_pkg::BIT_RST;
            net_s2_r <= fbs_pkg::BIT_RST;
        end
        else if (clk_en_in)
        begin
            net_s1_r <= net_fault_pin_in;
            net_s2_r <= net_s1_r;
        end
    end

    // [R03] network fault level
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            net_fault_r <= fbs_pkg::BIT_RST;
        else if (clk_en_in)
            net_fault_r <= net_s2_r;
    end

    // [R04] any slave faulted
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            slave_fault_r <= fbs_pkg::BIT_RST;
        else if (clk_en_in)
            slave_fault_r <= |slave_err_in;
    end

    // [R09] slave emulation mode
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            slave_emu_r <= fbs_pkg::BIT_RST;
        else if (clk_en_in)
            slave_emu_r <= slave_mode_cfg_in;
    end

    // [R10] [R11] host run, cleared on fault
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            host_run_r <= fbs_pkg::BIT_RST;
        else if (clk_en_in)
            host_run_r <= host_run_in && !host_fault_in;
    end

    // [R05] [R02] silence when off or backing off
    assign tx_en_nxt = !flags_nxt[fbs_pkg::FLAG_OFF_POS] && !bo.active_nxt;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            tx_en_r <= fbs_pkg::BIT_RST;
        else
            tx_en_r <= tx_en_nxt;
    end

    // [R06] [R07] [R08] process data gating
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            xchg_en_r <= fbs_pkg::BIT_RST;
            out_en_r  <= fbs_pkg::BIT_RST;
        end
        else
        begin
            xchg_en_r <= tx_en_nxt && (flags_nxt[fbs_pkg::FLAG_HELD_POS]
                                       || flags_nxt[fbs_pkg::FLAG_RUN_POS]);
            out_en_r  <= tx_en_nxt && flags_nxt[fbs_pkg::FLAG_RUN_POS];
        end
    end

    assign station_address_conflict_out = bo.active;
    assign network_fault_flag_out       = net_fault_r;
    assign slave_fault_flag_out         = slave_fault_r;
    assign bus_state_off_out            = flags_r[fbs_pkg::FLAG_OFF_POS];
    assign bus_state_halted_out         = flags_r[fbs_pkg::FLAG_HALTED_POS];
    assign bus_state_outputs_held_out   = flags_r[fbs_pkg::FLAG_HELD_POS];
    assign bus_state_running_out        = flags_r[fbs_pkg::FLAG_RUN_POS];
    assign slave_emulation_active_out   = slave_emu_r;
    assign host_cpu_running_out         = host_run_r;
    assign tx_enable_out                = tx_en_r;
    assign xchg_enable_out              = xchg_en_r;
    assign out_data_enable_out          = out_en_r;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_flags_onehot: assert property ($onehot(flags_r)) // [R12]
        else $error("bus state flags not one-hot");
    a_flags_match: assert property (flags_r == fbs_pkg::fbs_state_flags(state_r)) // [R05]
        else $error("bus state flags disagree with state");
    a_off_silent: assert property (bus_state_off_out |-> !tx_en_r && !xchg_en_r) // [R05]
        else $error("transmitting while bus off");
    a_halted_noxchg: assert property (bus_state_halted_out |-> !xchg_en_r && !out_en_r) // [R06]
        else $error("process data while halted");
    a_held_noout: assert property (bus_state_outputs_held_out |-> !out_en_r) // [R07]
        else $error("output data sent while held");
    a_run_full: assert property (bus_state_running_out && !bo.active |-> out_en_r && xchg_en_r) // [R08]
        else $error("running but exchange gated");
    a_backoff_silent: assert property (bo.active |-> !tx_en_r) // [R02]
        else $error("transmitting during back-off");
    a_conflict_flag: assert property (clk_en_in && addr_conflict_in // [R01]
                                      |=> station_address_conflict_out)
        else $error("conflict flag not raised");
    a_net_fault_lat: assert property (clk_en_in ##1 clk_en_in ##1 clk_en_in // [R03]
                                      |=> network_fault_flag_out == $past(net_fault_pin_in, 3))
        else $error("network fault flag not tracking pin");
    a_slave_fault: assert property (clk_en_in |=> slave_fault_r == |$past(slave_err_in)) // [R04]
        else $error("slave fault flag wrong");
    a_host_fault: assert property (clk_en_in && host_fault_in |=> !host_cpu_running_out) // [R11]
        else $error("host running shown in fault mode");
    a_host_run: assert property (clk_en_in && host_run_in && !host_fault_in // [R10]
                                 |=> host_cpu_running_out)
        else $error("host run mode not shown");
    a_slave_emu: assert property (clk_en_in |=> slave_emu_r == $past(slave_mode_cfg_in)) // [R09]
        else $error("slave emulation flag wrong");

    c_running: cover property (bus_state_running_out && out_en_r);
    c_held: cover property (bus_state_outputs_held_out && xchg_en_r);
    c_backoff: cover property (!bo.active ##1 bo.active);
    c_net_fault: cover property (network_fault_flag_out && bus_state_running_out);
endmodule
`default_nettype wire

// [rtl/fbs_pkg.sv]
// Purpose: shared constants and types of the fieldbus status flag block
// Assumes: 25 MHz system clock
// Notes:   times kept in their own unit, cycle counts derived here
package fbs_pkg;

    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned BACKOFF_TIME_MS = 5000;
    localparam int unsigned BACKOFF_CYCLES  = BACKOFF_TIME_MS * (CLK_HZ / 1000);

    localparam int unsigned SLAVE_COUNT     = 127;

    localparam int unsigned FLAG_OFF_POS    = 0;
    localparam int unsigned FLAG_HALTED_POS = 1;
    localparam int unsigned FLAG_HELD_POS   = 2;
    localparam int unsigned FLAG_RUN_POS    = 3;
    localparam int unsigned FLAG_W          = 4;

    localparam logic [3:0]  FLAGS_RST       = 4'h1;
    localparam logic        BIT_RST         = 1'b0;

    typedef enum logic [1:0] {
        BUS_OFF,
        BUS_HALTED,
        BUS_HELD,
        BUS_RUN
    } fbs_bus_state_t;

    localparam fbs_bus_state_t BUS_STATE_RST = BUS_OFF;

    // one-hot view of the bus state
    function automatic logic [FLAG_W-1:0] fbs_state_flags(input fbs_bus_state_t st);
        logic [FLAG_W-1:0] f;
        f = '0;
        unique case (st)
            BUS_OFF:    f[FLAG_OFF_POS]    = 1'b1;
            BUS_HALTED: f[FLAG_HALTED_POS] = 1'b1;
            BUS_HELD:   f[FLAG_HELD_POS]   = 1'b1;
            BUS_RUN:    f[FLAG_RUN_POS]    = 1'b1;
        endcase
        return f;
    endfunction

endpackage

// [rtl/fbs_backoff_if.sv]
// Purpose: carrier between the flag bank and its back-off timer
// Assumes: single clock domain
// Notes:   conflict is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface fbs_backoff_if;
    logic en;
    logic conflict;
    logic active;
    logic active_nxt;

    modport ctl
    (
        output en,
        output conflict,
        input  active,
        input  active_nxt
    );

    modport tmr
    (
        input  en,
        input  conflict,
        output active,
        output active_nxt
    );
endinterface
`default_nettype wire

// [rtl/fbs_backoff.sv]
// Purpose: retriggerable silence timer after a station address conflict
// Assumes: conflict pulse from same-clock receive logic
// Notes:   each new conflict restarts the full interval
`timescale 1ns/1ps
`default_nettype none
module fbs_backoff #(
    parameter int unsigned BACKOFF_CYC = fbs_pkg::BACKOFF_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    fbs_backoff_if.tmr bo
);
    localparam int unsigned CNT_W = (BACKOFF_CYC > 1) ? $clog2(BACKOFF_CYC) : 1;
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(BACKOFF_CYC - 1);

    generate
        if (BACKOFF_CYC < 2)
        begin : g_chk
            $error("back-off interval must be at least two cycles");
        end
    endgenerate

    logic [CNT_W-1:0] cnt_r;
    logic             active_r;
    logic             active_nxt;

    always_comb
    begin
        active_nxt = active_r;
        if (bo.en)
        begin
            if (bo.conflict)
                active_nxt = 1'b1;
            else if (active_r && cnt_r == '0)
                active_nxt = 1'b0;
        end
    end

    // [R01] enter back-off
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            active_r <= fbs_pkg::BIT_RST;
        else
            active_r <= active_nxt;
    end

    // [R02] retriggered interval count
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cnt_r <= '0;
        else if (bo.en)
        begin
            if (bo.conflict)
                cnt_r <= CNT_LOAD;
            else if (active_r && cnt_r != '0)
                cnt_r <= cnt_r - CNT_W'(1);
        end
    end

    assign bo.active     = active_r;
    assign bo.active_nxt = active_nxt;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_conflict_reload: assert property (bo.en && bo.conflict |=> active_r && cnt_r == CNT_LOAD) // [R02]
        else $error("conflict did not restart back-off");
    a_backoff_count: assert property (bo.en && !bo.conflict && active_r && cnt_r != '0 // [R02]
                                      |=> active_r && cnt_r == $past(cnt_r) - CNT_W'(1))
        else $error("back-off count did not step down");
    a_backoff_expire: assert property (bo.en && !bo.conflict && active_r && cnt_r == '0 // [R02]
                                       |=> !active_r)
        else $error("back-off did not end at zero");
    a_backoff_frozen: assert property (!bo.en |=> $stable(cnt_r) && $stable(active_r)) // [R02]
        else $error("back-off moved while disabled");

    c_backoff_retrig: cover property (active_r && bo.en && bo.conflict);
endmodule
`default_nettype wire

// [testbench/fbs_slave_model.sv]
// Purpose: behavioural slaves and cable on the fieldbus
// Assumes: bench commands in the clk_in domain
// Notes:   each command shows one clock later
`timescale 1ns/1ps
`default_nettype none
module fbs_slave_model #(
    parameter int unsigned SLV_N = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             dup_cmd_in,
    input  wire logic             cable_cmd_in,
    input  wire logic [SLV_N-1:0] fail_cmd_in,
    output logic                  dup_out,
    output logic                  cable_out,
    output logic [SLV_N-1:0]      fail_out
);
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            dup_out <= 1'b0;
        else
            dup_out <= dup_cmd_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cable_out <= 1'b0;
            fail_out  <= '0;
        end
        else
        begin
            cable_out <= cable_cmd_in;
            fail_out  <= fail_cmd_in;
        end
    end
endmodule
`default_nettype wire

// [testbench/tb_fieldbus_master_status_flags.sv]
// Purpose: self-checking bench of the status flag bank
// Assumes: back-off shortened to 8 cycles
// Notes:   inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_master_status_flags;
    localparam int unsigned BO = 8;
    localparam int unsigned SN = 16;
    logic          clk_in, rst_n_in, clk_en, mode, hrun, hflt, dup_c, cab_c;
    logic          dup, cab, cf, nf, sf, off, hlt, hld, run, emu, hst, tx, xc, oe;
    logic [1:0]    req;
    logic [SN-1:0] fail_c, fail;
    int            err_total, comparisons, hi;

    fbs_slave_model #(.SLV_N(SN)) i_slv (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .dup_cmd_in(dup_c), .cable_cmd_in(cab_c), .fail_cmd_in(fail_c),
        .dup_out(dup), .cable_out(cab), .fail_out(fail));

    fbs_status_flags #(.BACKOFF_CYC(BO), .SLV_N(SN)) i_dut (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .clk_en_in(clk_en), .addr_conflict_in(dup),
        .net_fault_pin_in(cab), .slave_err_in(fail), .bus_state_req_in(req),
        .slave_mode_cfg_in(mode), .host_run_in(hrun), .host_fault_in(hflt),
        .station_address_conflict_out(cf), .network_fault_flag_out(nf),
        .slave_fault_flag_out(sf), .bus_state_off_out(off), .bus_state_halted_out(hlt),
        .bus_state_outputs_held_out(hld), .bus_state_running_out(run),
        .slave_emulation_active_out(emu), .host_cpu_running_out(hst),
        .tx_enable_out(tx), .xchg_enable_out(xc), .out_data_enable_out(oe));

    task automatic close_out();
        $display("counts: comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task automatic check_state(input int s);
        check({4'h0, run, hld, hlt, off}, 8'h01 << s, "state flags");
    endtask

    // gating of transmission and exchange, every cycle
    always @(negedge clk_in)
    begin
        if (rst_n_in)
        begin
            check({5'h00, tx, xc, oe},
                  {5'h00, !off && !cf, !cf && (hld || run), !cf && run}, "gates");
            if (cf === 1'b1)
                hi++;
        end
    end

    task automatic t_states();
        int seq[5] = '{3, 1, 2, 0, 3};
        foreach (seq[i])
        begin
            @(posedge clk_in);
            req <= 2'(seq[i]);
            settle(1);
            check_state(seq[i]);
        end
        $display("test states done");
    endtask

    task automatic pulse_dup();
        @(posedge clk_in);
        dup_c <= 1'b1;
        @(posedge clk_in);
        dup_c <= 1'b0;
    endtask

    task automatic drain_backoff(input int exp_len);
        int n;
        n = 0;
        while (cf !== 1'b0 && n < 100)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n == 100)
        begin
            err_total++;
            $display("[FAIL] t=%0t back-off never ended", $time);
            close_out();
        end
        else
            check(8'(hi), 8'(exp_len), "back-off length");
    endtask

    task automatic t_backoff(input int gap);
        hi = 0;
        pulse_dup();
        if (gap > 0)
        begin
            repeat (gap) @(posedge clk_in);
            pulse_dup();
        end
        settle(1);
        drain_backoff(BO + ((gap > 0) ? gap + 2 : 0));
        $display("test back-off gap %0d done", gap);
    endtask

    task automatic t_net();
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge clk_in);
            cab_c <= 1'(v);
            settle(3);
            check(8'(nf), 8'(1 - v), "net fault early");
            settle(1);
            check(8'(nf), 8'(v), "net fault");
        end
        $display("test net fault done");
    endtask

    task automatic t_slaves();
        for (int b = 0; b < 3; b++)
        begin
            @(posedge clk_in);
            fail_c <= (b == 2) ? '0 : (SN'(1) << ((b == 0) ? 0 : SN - 1));
            settle(2);
            check(8'(sf), 8'(b != 2), "slave fault");
        end
        $display("test slave fault done");
    endtask

    task automatic t_host();
        logic [2:0] tab[4] = '{3'b101, 3'b000, 3'b111, 3'b010};
        foreach (tab[i])
        begin
            @(posedge clk_in);
            {hrun, hflt, mode} <= tab[i];
            settle(1);
            check(8'(hst), 8'(tab[i][2] && !tab[i][1]), "host run");
            check(8'(emu), 8'(tab[i][0]), "slave emulation");
        end
        $display("test host done");
    endtask

    task automatic t_freeze();
        hi = 0;
        pulse_dup();
        @(posedge clk_in);
        clk_en <= 1'b0;
        req <= 2'h0;
        settle(2);
        check_state(3);
        check(8'(cf), 8'h01, "back-off frozen");
        @(posedge clk_in);
        clk_en <= 1'b1;
        settle(1);
        check_state(0);
        drain_backoff(BO + 3);
        $display("test freeze done");
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    initial
    begin
        {err_total, comparisons, hi} = '0;
        {rst_n_in, mode, hrun, hflt, dup_c, cab_c, req, fail_c} = '0;
        clk_en = 1'b1;
        repeat (10) @(posedge clk_in);
        @(negedge clk_in);
        check_state(0);
        check({cf, nf, sf, emu, hst, tx, xc, oe}, 8'h00, "reset");
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        $display("test reset done");
        t_states();
        t_backoff(0);
        t_backoff(3);
        t_net();
        t_slaves();
        t_host();
        t_freeze();
        close_out();
    end
endmodule
`default_nettype wire
